// >>> hw/interval_timer.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Mode, unit, reset, start and stop commands are taken in every mode.
// - Four modes exist (free, pulse, toggle, pwm) and free is the mode after power-up.
// - The time base is seconds, milliseconds or microseconds, milliseconds after power-up.
// - A reset command stops timing at once, clears the counting logic and drives the pin low.
// - The state reads 0 when stopped and a value from 1 to 4 while running.
// - A start command begins timing with the mode, unit and settings configured now.
// - A stop command halts timing once any tick in its own cycle has updated the count, and the pin keeps its level.
// - Free mode counts up or down by the direction setting, up after power-up.
// - A down count starts from the loaded value.
// - An up count always starts at zero and ignores the loaded value.
// - The count can be read back as the present free-mode count in the chosen unit.
// - Pulse, toggle and pwm modes drive a pulse, a toggle, or an endless pulse train on the pin.
module interval_timer #(
	parameter int CNT_W = 64
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             timer_out
);

	interval_timer_pkg::mode_t mode_q;
	interval_timer_pkg::mode_t run_mode_q;
	interval_timer_pkg::unit_t unit_q;
	interval_timer_pkg::unit_t run_unit_q;
	logic                      dir_down_q;
	logic                      run_down_q;
	logic [63:0]               load_q;
	logic [31:0]               period_q;
	logic [CNT_W-1:0]          count_q;
	logic [31:0]               count_hi_q;
	logic                      running_q;
	logic [7:0]                awaddr_q;
	logic                      aw_got_q;
	logic [31:0]               wdata_q;
	logic [3:0]                wstrb_q;
	logic                      w_got_q;
	logic [1:0]                bresp_q;
	logic                      bvalid_q;
	logic [31:0]               rdata_q;
	logic [1:0]                rresp_q;
	logic                      rvalid_q;
	logic                      do_wr;
	logic                      wr_cmd;
	logic                      cmd_start;
	logic                      cmd_stop;
	logic                      cmd_reset;
	logic                      tick;
	logic [2:0]                state_val;
	logic [CNT_W-1:0]          period_cnt;
	logic                      period_done;
	logic                      wr_known;
	logic                      rd_known;
	logic [31:0]               rd_val;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// write channel: address and data taken in either order
	assign awready = !aw_got_q && !bvalid_q;
	assign wready  = !w_got_q && !bvalid_q;
	assign do_wr   = aw_got_q && w_got_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (awvalid && awready) begin
			aw_got_q <= 1'b1;
			awaddr_q <= awaddr;
		end else if (do_wr) begin
			aw_got_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_got_q <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (do_wr) begin
			w_got_q <= 1'b0;
		end
	end

	always_comb begin
		case (awaddr_q)
			interval_timer_pkg::CFG_OFF,
			interval_timer_pkg::CMD_OFF,
			interval_timer_pkg::LOAD_LO_OFF,
			interval_timer_pkg::LOAD_HI_OFF,
			interval_timer_pkg::PERIOD_OFF: wr_known = 1'b1;
			default:                        wr_known = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= interval_timer_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_known ? interval_timer_pkg::RESP_OKAY : interval_timer_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// configuration registers, writable in any mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q     <= interval_timer_pkg::MODE_RST;
			unit_q     <= interval_timer_pkg::UNIT_RST;
			dir_down_q <= interval_timer_pkg::DIR_RST;
			load_q     <= 64'h0000_0000_0000_0000;
			period_q   <= interval_timer_pkg::PERIOD_RST;
		end else if (do_wr) begin
			case (awaddr_q)
				interval_timer_pkg::CFG_OFF: begin
					if (wstrb_q[0]) begin
						mode_q     <= interval_timer_pkg::mode_t'(wdata_q[interval_timer_pkg::CFG_MODE_LSB +: 2]);
						if (wdata_q[interval_timer_pkg::CFG_UNIT_LSB +: 2] != 2'b11) begin
							unit_q <= interval_timer_pkg::unit_t'(wdata_q[interval_timer_pkg::CFG_UNIT_LSB +: 2]);
						end
						dir_down_q <= wdata_q[interval_timer_pkg::CFG_DIR_BIT];
					end
				end
				interval_timer_pkg::LOAD_LO_OFF: load_q[31:0]  <= merge(load_q[31:0], wdata_q, wstrb_q);
				interval_timer_pkg::LOAD_HI_OFF: load_q[63:32] <= merge(load_q[63:32], wdata_q, wstrb_q);
				interval_timer_pkg::PERIOD_OFF:  period_q      <= merge(period_q, wdata_q, wstrb_q);
				default: begin
				end
			endcase
		end
	end

	// command strobes: reset over stop over start
	assign wr_cmd    = do_wr && (awaddr_q == interval_timer_pkg::CMD_OFF) && wstrb_q[0];
	assign cmd_reset = wr_cmd && wdata_q[interval_timer_pkg::CMD_RESET_BIT];
	assign cmd_stop  = wr_cmd && !cmd_reset && wdata_q[interval_timer_pkg::CMD_STOP_BIT];
	assign cmd_start = wr_cmd && !cmd_reset && !cmd_stop && wdata_q[interval_timer_pkg::CMD_START_BIT];

	unit_tick u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (cmd_start || cmd_reset),
		.unit    (run_unit_q),
		.tick    (tick)
	);

	assign period_cnt  = (period_q == 32'h0000_0000) ? CNT_W'(1) : CNT_W'(period_q);
	assign period_done = (count_q + CNT_W'(1)) >= period_cnt;

	// run state and latched settings
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			running_q  <= 1'b0;
			run_mode_q <= interval_timer_pkg::MODE_RST;
			run_unit_q <= interval_timer_pkg::UNIT_RST;
			run_down_q <= interval_timer_pkg::DIR_RST;
		end else if (cmd_reset || cmd_stop) begin
			running_q <= 1'b0;
		end else if (cmd_start) begin
			running_q  <= 1'b1;
			run_mode_q <= mode_q;
			run_unit_q <= unit_q;
			run_down_q <= dir_down_q;
		end else if (running_q && tick && period_done &&
		             (run_mode_q == interval_timer_pkg::MODE_PULSE ||
		              run_mode_q == interval_timer_pkg::MODE_TOGGLE)) begin
			running_q <= 1'b0;
		end
	end

	// count register
	always_ff @(posedge aclk) begin
		if (!aresetn || cmd_reset) begin
			count_q <= '0;
		end else if (cmd_start) begin
			if (mode_q == interval_timer_pkg::MODE_FREE && dir_down_q) begin
				count_q <= CNT_W'(load_q);
			end else begin
				count_q <= '0;
			end
		end else if (running_q && tick) begin
			if (run_mode_q != interval_timer_pkg::MODE_FREE) begin
				count_q <= period_done ? '0 : count_q + CNT_W'(1);
			end else if (!run_down_q) begin
				count_q <= count_q + CNT_W'(1);
			end else if (count_q != '0) begin
				count_q <= count_q - CNT_W'(1);
			end
		end
	end

	// output pin
	always_ff @(posedge aclk) begin
		if (!aresetn || cmd_reset) begin
			timer_out <= 1'b0;
		end else if (cmd_start && mode_q == interval_timer_pkg::MODE_PULSE) begin
			timer_out <= 1'b1;
		end else if (running_q && tick && period_done && !cmd_stop) begin
			case (run_mode_q)
				interval_timer_pkg::MODE_PULSE:  timer_out <= 1'b0;
				interval_timer_pkg::MODE_TOGGLE: timer_out <= !timer_out;
				interval_timer_pkg::MODE_PWM:    timer_out <= !timer_out;
				default:                         timer_out <= timer_out;
			endcase
		end
	end

	// read channel
	assign state_val = running_q ? 3'(run_mode_q) + 3'h1 : 3'h0;
	assign arready   = !rvalid_q;
	assign rvalid    = rvalid_q;
	assign rdata     = rdata_q;
	assign rresp     = rresp_q;

	always_comb begin
		rd_known = 1'b1;
		case (araddr)
			interval_timer_pkg::CFG_OFF:      rd_val = {27'h0, dir_down_q, unit_q, mode_q};
			interval_timer_pkg::CMD_OFF:      rd_val = 32'h0000_0000;
			interval_timer_pkg::STATE_OFF:    rd_val = {29'h0, state_val};
			interval_timer_pkg::LOAD_LO_OFF:  rd_val = load_q[31:0];
			interval_timer_pkg::LOAD_HI_OFF:  rd_val = load_q[63:32];
			interval_timer_pkg::COUNT_LO_OFF: rd_val = count_q[31:0];
			interval_timer_pkg::COUNT_HI_OFF: rd_val = count_hi_q;
			interval_timer_pkg::PERIOD_OFF:   rd_val = period_q;
			default: begin
				rd_val   = 32'h0000_0000;
				rd_known = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= interval_timer_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_val;
			rresp_q  <= rd_known ? interval_timer_pkg::RESP_OKAY : interval_timer_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// upper half snapshot taken with the lower half
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_hi_q <= 32'h0000_0000;
		end else if (arvalid && arready && araddr == interval_timer_pkg::COUNT_LO_OFF) begin
			count_hi_q <= count_q[63:32];
		end
	end

	// checks
	sequence s_start_free(logic down);
		cmd_start && mode_q == interval_timer_pkg::MODE_FREE && dir_down_q == down;
	endsequence

	sequence s_down_at_zero;
		running_q && run_mode_q == interval_timer_pkg::MODE_FREE && run_down_q && count_q == '0;
	endsequence

	a_power_up_cfg: assert property (@(posedge aclk)
		$rose(aresetn) |-> mode_q == interval_timer_pkg::MODE_FREE && unit_q == interval_timer_pkg::UNIT_MS
			&& !dir_down_q)
		else $error("config not at power-up values");

	a_reset_cmd_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_reset |=> !running_q && !timer_out && count_q == '0)
		else $error("reset command did not clear timer");

	a_stop_holds_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_stop |=> !running_q && timer_out == $past(timer_out))
		else $error("stop did not halt or pin moved");

	a_state_range: assert property (@(posedge aclk) disable iff (!aresetn)
		(running_q |-> state_val >= 3'h1 && state_val <= 3'h5) and (!running_q |-> state_val == 3'h0))
		else $error("state value out of range");

	a_up_from_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start_free(1'b0) |=> running_q && count_q == '0)
		else $error("up count did not start at zero");

	a_down_from_load: assert property (@(posedge aclk) disable iff (!aresetn)
		s_start_free(1'b1) |=> running_q && count_q == CNT_W'($past(load_q)))
		else $error("down count did not load start value");

	a_down_floor: assert property (@(posedge aclk) disable iff (!aresetn)
		s_down_at_zero ##0 !wr_cmd |=> count_q == '0)
		else $error("down count passed zero");

	a_up_step: assert property (@(posedge aclk) disable iff (!aresetn)
		running_q && run_mode_q == interval_timer_pkg::MODE_FREE && !run_down_q && tick && !wr_cmd
			|=> count_q == $past(count_q) + CNT_W'(1))
		else $error("up count did not step by one");

	a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr |=> bvalid && (wr_known == $past(wr_known)) ##0 bresp == ($past(wr_known) ?
			interval_timer_pkg::RESP_OKAY : interval_timer_pkg::RESP_SLVERR))
		else $error("write response missing or wrong");

	a_pwm_toggles: assert property (@(posedge aclk) disable iff (!aresetn)
		running_q && run_mode_q == interval_timer_pkg::MODE_PWM && tick && period_done && !wr_cmd
			|=> timer_out != $past(timer_out) && running_q)
		else $error("pwm did not toggle");

endmodule

`default_nettype wire

// >>> hw/unit_tick.sv
`timescale 1ns/100ps
`default_nettype none

module unit_tick (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     clear,
	input  wire interval_timer_pkg::unit_t unit,
	output logic                          tick
);

	localparam logic [5:0] US_LAST  = 6'(interval_timer_pkg::CYC_PER_US - 1);
	localparam logic [9:0] MS_LAST  = 10'(interval_timer_pkg::US_PER_MS - 1);
	localparam logic [9:0] SEC_LAST = 10'(interval_timer_pkg::MS_PER_SEC - 1);

	logic [5:0] cyc_q;
	logic [9:0] us_q;
	logic [9:0] ms_q;
	logic       us_tick;
	logic       ms_tick;
	logic       sec_tick;

	assign us_tick  = (cyc_q == US_LAST);
	assign ms_tick  = us_tick && (us_q == MS_LAST);
	assign sec_tick = ms_tick && (ms_q == SEC_LAST);

	// cascaded dividers: cycles to us, us to ms, ms to s
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			cyc_q <= 6'h00;
			us_q  <= 10'h000;
			ms_q  <= 10'h000;
		end else begin
			cyc_q <= us_tick ? 6'h00 : cyc_q + 6'h01;
			if (us_tick) begin
				us_q <= ms_tick ? 10'h000 : us_q + 10'h001;
			end
			if (ms_tick) begin
				ms_q <= sec_tick ? 10'h000 : ms_q + 10'h001;
			end
		end
	end

	always_comb begin
		case (unit)
			interval_timer_pkg::UNIT_SEC: tick = sec_tick;
			interval_timer_pkg::UNIT_US:  tick = us_tick;
			default:                      tick = ms_tick;
		endcase
	end

endmodule

`default_nettype wire

// >>> include/interval_timer_pkg.sv
package interval_timer_pkg;

	// register byte offsets
	localparam logic [7:0] CFG_OFF      = 8'h00;
	localparam logic [7:0] CMD_OFF      = 8'h04;
	localparam logic [7:0] STATE_OFF    = 8'h08;
	localparam logic [7:0] LOAD_LO_OFF  = 8'h0C;
	localparam logic [7:0] LOAD_HI_OFF  = 8'h10;
	localparam logic [7:0] COUNT_LO_OFF = 8'h14;
	localparam logic [7:0] COUNT_HI_OFF = 8'h18;
	localparam logic [7:0] PERIOD_OFF   = 8'h1C;

	// configuration fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_UNIT_LSB = 2;
	localparam int CFG_DIR_BIT  = 4;

	// command bits
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT  = 1;
	localparam int CMD_RESET_BIT = 2;

	typedef enum logic [1:0] {
		MODE_FREE   = 2'b00,
		MODE_PULSE  = 2'b01,
		MODE_TOGGLE = 2'b10,
		MODE_PWM    = 2'b11
	} mode_t;

	typedef enum logic [1:0] {
		UNIT_SEC = 2'b00,
		UNIT_MS  = 2'b01,
		UNIT_US  = 2'b10
	} unit_t;

	// reset values
	localparam mode_t      MODE_RST   = MODE_FREE;
	localparam unit_t      UNIT_RST   = UNIT_MS;
	localparam logic       DIR_RST    = 1'b0;
	localparam logic [31:0] PERIOD_RST = 32'h0000_0001;

	// timing
	localparam int CLK_PERIOD_PS = 25000;
	localparam int US_PS         = 1000000;
	localparam int CYC_PER_US    = US_PS / CLK_PERIOD_PS;
	localparam int US_PER_MS     = 1000;
	localparam int MS_PER_SEC    = 1000;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> testbench/interval_timer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module interval_timer_tb_top;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        timer_out;
	int          bad_count;
	int          tests_run;
	int          cycles;
	logic [1:0]  rsp;
	logic [63:0] val;

	interval_timer #(.CNT_W(64)) interval_timer_i (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .timer_out(timer_out)
	);

	always #12.5 aclk = ~aclk;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count = bad_count + 1;
			print_verdict();
		end
	end

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ap;
		bit wp;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ap = 1;
		wp = 1;
		while (ap || wp) begin
			@(posedge aclk);
			if (ap && awready === 1'b1) begin
				ap = 0;
				awvalid <= 1'b0;
			end
			if (wp && wready === 1'b1) begin
				wp = 0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, rsp);
		check("write response", 64'(rsp), 64'(interval_timer_pkg::RESP_OKAY));
	endtask

	task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		axi_read(a, d, rsp);
		check(name, 64'(d), 64'(exp));
	endtask

	task automatic read_count(output logic [63:0] c);
		logic [31:0] lo;
		logic [31:0] hi;
		axi_read(interval_timer_pkg::COUNT_LO_OFF, lo, rsp);
		axi_read(interval_timer_pkg::COUNT_HI_OFF, hi, rsp);
		c = {hi, lo};
	endtask

	function automatic logic [31:0] cfg(input logic [1:0] m, input logic [1:0] u, input logic d);
		return {27'h0, d, u, m};
	endfunction

	task automatic wait_units(input int k);
		repeat (40 * k + 12) @(posedge aclk);
	endtask

	task automatic reset_values();
		rd_check("cfg reset", interval_timer_pkg::CFG_OFF, cfg(2'h0, 2'h1, 1'b0));
		rd_check("state reset", interval_timer_pkg::STATE_OFF, 32'h0);
		rd_check("period reset", interval_timer_pkg::PERIOD_OFF, 32'h1);
		rd_check("count reset", interval_timer_pkg::COUNT_LO_OFF, 32'h0);
	endtask

	task automatic bus_refusals();
		logic [31:0] d;
		axi_write(interval_timer_pkg::STATE_OFF, 32'h5, rsp);
		check("state write resp", 64'(rsp), 64'(interval_timer_pkg::RESP_SLVERR));
		axi_read(8'h40, d, rsp);
		check("unmapped read resp", 64'(rsp), 64'(interval_timer_pkg::RESP_SLVERR));
		check("unmapped read data", 64'(d), 64'h0);
		for (int i = 0; i < 4; i++) begin
			wr(interval_timer_pkg::CFG_OFF, cfg(2'(i), 2'(i % 3), 1'(i)));
			rd_check("cfg readback", interval_timer_pkg::CFG_OFF, cfg(2'(i), 2'(i % 3), 1'(i)));
		end
		wr(interval_timer_pkg::CFG_OFF, cfg(2'h1, 2'h3, 1'b0));
		rd_check("cfg unit kept", interval_timer_pkg::CFG_OFF, cfg(2'h1, 2'h0, 1'b0));
	endtask

	task automatic free_counts();
		wr(interval_timer_pkg::CFG_OFF, cfg(2'h0, 2'h1, 1'b0));
		wr(interval_timer_pkg::CMD_OFF, 32'h1);
		wait_units(3);
		read_count(val);
		check("ms unit no early tick", val, 64'h0);
		wr(interval_timer_pkg::CMD_OFF, 32'h2);
		wr(interval_timer_pkg::LOAD_LO_OFF, 32'h64);
		wr(interval_timer_pkg::LOAD_HI_OFF, 32'h0);
		wr(interval_timer_pkg::CFG_OFF, cfg(2'h0, 2'h2, 1'b0));
		wr(interval_timer_pkg::CMD_OFF, 32'h1);
		rd_check("state up running", interval_timer_pkg::STATE_OFF, 32'h1);
		wait_units(3);
		wr(interval_timer_pkg::CMD_OFF, 32'h2);
		read_count(val);
		check("up count", val, 64'h3);
		rd_check("state stopped", interval_timer_pkg::STATE_OFF, 32'h0);
		wr(interval_timer_pkg::LOAD_LO_OFF, 32'h2);
		wr(interval_timer_pkg::LOAD_HI_OFF, 32'h1);
		wr(interval_timer_pkg::CFG_OFF, cfg(2'h0, 2'h2, 1'b1));
		wr(interval_timer_pkg::CMD_OFF, 32'h1);
		wait_units(3);
		wr(interval_timer_pkg::CMD_OFF, 32'h2);
		read_count(val);
		check("down count borrow", val, 64'h0000_0000_FFFF_FFFF);
		wr(interval_timer_pkg::LOAD_HI_OFF, 32'h0);
		wr(interval_timer_pkg::CMD_OFF, 32'h1);
		wait_units(4);
		read_count(val);
		check("down holds at zero", val, 64'h0);
		rd_check("state still running", interval_timer_pkg::STATE_OFF, 32'h1);
		wr(interval_timer_pkg::CMD_OFF, 32'h2);
	endtask

	task automatic output_modes();
		wr(interval_timer_pkg::PERIOD_OFF, 32'h2);
		wr(interval_timer_pkg::CFG_OFF, cfg(2'h1, 2'h2, 1'b0));
		wr(interval_timer_pkg::CMD_OFF, 32'h1);
		check("pulse pin high", 64'(timer_out), 64'h1);
		rd_check("state pulse", interval_timer_pkg::STATE_OFF, 32'h2);
		repeat (100) @(posedge aclk);
		check("pulse pin low", 64'(timer_out), 64'h0);
		wr(interval_timer_pkg::PERIOD_OFF, 32'h1);
		wr(interval_timer_pkg::CFG_OFF, cfg(2'h2, 2'h2, 1'b0));
		wr(interval_timer_pkg::CMD_OFF, 32'h1);
		repeat (60) @(posedge aclk);
		check("toggle pin", 64'(timer_out), 64'h1);
		rd_check("toggle done", interval_timer_pkg::STATE_OFF, 32'h0);
		wr(interval_timer_pkg::CFG_OFF, cfg(2'h3, 2'h2, 1'b0));
		wr(interval_timer_pkg::CMD_OFF, 32'h1);
		rd_check("state pwm", interval_timer_pkg::STATE_OFF, 32'h4);
		repeat (40) @(posedge aclk);
		wr(interval_timer_pkg::CMD_OFF, 32'h2);
		repeat (80) @(posedge aclk);
		check("pin held after stop", 64'(timer_out), 64'h0);
		wr(interval_timer_pkg::CMD_OFF, 32'h1);
		rd_check("pwm restarted", interval_timer_pkg::STATE_OFF, 32'h4);
		repeat (40) @(posedge aclk);
		check("pwm pin high", 64'(timer_out), 64'h1);
		wr(interval_timer_pkg::CMD_OFF, 32'h4);
		check("pin low on reset", 64'(timer_out), 64'h0);
		rd_check("state after reset", interval_timer_pkg::STATE_OFF, 32'h0);
		read_count(val);
		check("count after reset", val, 64'h0);
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		bad_count = 0;
		tests_run = 0;
		cycles = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		reset_values();
		bus_refusals();
		free_counts();
		output_modes();
		print_verdict();
	end
endmodule

`default_nettype wire
